/* File: ebaws_cfg.svh */
// Register map, field layout and fixed window constants for the window selector
`ifndef EBAWS_CFG_SVH
`define EBAWS_CFG_SVH
`define EBAWS_OFF_RSTCFG    16'hf108
`define EBAWS_OFF_SEL1      16'hf000
`define EBAWS_OFF_SEL2      16'hf004
`define EBAWS_OFF_SEL3      16'hf008
`define EBAWS_OFF_SEL4      16'hf00c
`define EBAWS_OFF_MODE0     16'hf010
`define EBAWS_OFF_MODE1     16'hf014
`define EBAWS_OFF_MODE2     16'hf018
`define EBAWS_OFF_MODE3     16'hf01c
`define EBAWS_OFF_MODE4     16'hf020
`define EBAWS_OFF_ROUTE     16'hf024
`define EBAWS_SZ_LSB        0
`define EBAWS_SZ_MSB        3
`define EBAWS_SA_LSB        4
`define EBAWS_SA_MSB        15
`define EBAWS_SZ_MAXCODE    4'hb
`define EBAWS_SEL_RESET     16'h0000
`define EBAWS_MODE_RESET    16'h0000
`define EBAWS_XP_MODE_RESET 16'h0000
`define EBAWS_XP0_START     12'h00e
`define EBAWS_XP0_SIZE      4'h0
`define EBAWS_XP1_START     12'h00f
`define EBAWS_XP1_SIZE      4'h0
`define EBAWS_RC_WRC        0
`define EBAWS_RC_CS_LSB     1
`define EBAWS_RC_SA_LSB     3
`define EBAWS_RC_CK_LSB     5
`define EBAWS_RC_CK_MSB     7
`endif

/* File: ebaws_pkg.sv */
// Types shared by the window selector files
package ebaws_pkg;
  typedef enum logic [2:0] {SRC_DEFAULT, SRC_WIN1, SRC_WIN2, SRC_WIN3, SRC_WIN4,
                            SRC_XP0, SRC_XP1} ebaws_src_e;
  typedef logic [15:0] ebaws_word_t;
endpackage

/* File: ebaws_match_if.sv */
// Window compare bundle between the top and the matcher
`timescale 1ns/10ps
interface ebaws_match_if;
  logic [23:0]  addr;
  logic [15:0]  sel [4];
  logic [3:0]   winHit;
  logic [1:0]   xpHit;
  modport top (output addr, output sel, input winHit, input xpHit);
  modport match (input addr, input sel, output winHit, output xpHit);
endinterface

/* File: ebaws_matcher.sv */
// Combinational compare of an address against programmable and fixed windows
`timescale 1ns/10ps
`include "ebaws_cfg.svh"
module ebaws_matcher (
  ebaws_match_if.match m
);
  // Compare only the start bits above the window size; reserved sizes never match
  function automatic logic winMatch(input logic [23:0] a, input logic [3:0] sz,
                                    input logic [11:0] st);
    logic [11:0] mask;
    mask = 12'hfff << sz;
    if (sz > `EBAWS_SZ_MAXCODE) begin
      return 1'b0;
    end
    return ((a[23:12] ^ st) & mask) == 12'h000;
  endfunction

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      m.winHit[i] = winMatch(m.addr, m.sel[i][`EBAWS_SZ_MSB:`EBAWS_SZ_LSB],
                             m.sel[i][`EBAWS_SA_MSB:`EBAWS_SA_LSB]);
    end
    m.xpHit[0] = winMatch(m.addr, `EBAWS_XP0_SIZE, `EBAWS_XP0_START);
    m.xpHit[1] = winMatch(m.addr, `EBAWS_XP1_SIZE, `EBAWS_XP1_START);
  end
endmodule

/* File: ebaws_top.sv */
// External bus address window selector with APB register access
// Functional notes
// - Four programmable windows, each with its own bus mode register.
// - Each window select register carves out one window using its mode register.
// - Size code 0000 is 4 KByte doubling to 1011 8 MByte; 11xx reserved.
// - Start bits inside the window size are ignored in the compare.
// - Every access compared against all windows, resolved in four priority levels.
// - Fixed peripheral window match wins, using its own bus mode register.
// - Windows 2 and 4 beat windows 1 and 3.
// - Third level: window 1 or 3 uses its own mode register.
// - No match at all selects the default mode register.
// - Fixed peripheral windows never overlap.
// - Write style bit: 0 byte strobes, 1 single strobe plus high enable.
// - Chip select count: 00 three, 01 two, 10 none, 11 five.
// - Segment lines: 00 four, 01 none, 10 eight, 11 two.
// - Clock field reports the clock generation mode.
// - Reset configuration register ignores writes, reads latched value.
// - Default mode register has no select register and covers everything else.
// - Select register holds size field and start field.
`timescale 1ns/10ps
`include "ebaws_cfg.svh"
module ebaws_top (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [15:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [23:0]           accessAddr,
  output ebaws_pkg::ebaws_src_e      routeSrc,
  output ebaws_pkg::ebaws_word_t     routeMode,
  output logic                       routeExternal,
  output logic                       lowByteWriteStrobeEn,
  output logic [2:0]                 chipSelectLines,
  output logic [3:0]                 segmentLineCount,
  output logic [2:0]                 clockGenMode,
  input  wire logic                  cfgWriteStyle,
  input  wire logic [1:0]            cfgChipSelect,
  input  wire logic [1:0]            cfgSegment,
  input  wire logic [2:0]            cfgClock
);
  logic        rstSync1;
  logic        rstSync;
  logic [7:0]  pinMeta;
  logic [7:0]  pinSync;
  logic        latchDone;
  logic [1:0]  latchArm;
  logic [1:0]  next_latchArm;
  logic [7:0]  resetPinConfiguration;
  logic [7:0]  next_resetPinConfiguration;
  logic        next_latchDone;
  ebaws_pkg::ebaws_word_t windowSelectReg [4];
  ebaws_pkg::ebaws_word_t windowBusModeReg [4];
  ebaws_pkg::ebaws_word_t defaultBusModeReg;
  ebaws_pkg::ebaws_word_t next_windowSelectReg [4];
  ebaws_pkg::ebaws_word_t next_windowBusModeReg [4];
  ebaws_pkg::ebaws_word_t next_defaultBusModeReg;
  ebaws_pkg::ebaws_word_t onchipPeriphBusModeReg [2];
  logic [31:0] next_prdata;
  logic        wrEn;
  ebaws_match_if mIf ();

  // Reset is released through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync  <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync  <= rstSync1;
    end
  end

  // Strap pins come from outside; two flops before use
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pinMeta <= 8'h00;
      pinSync <= 8'h00;
    end else begin
      pinMeta <= {cfgClock, cfgSegment, cfgChipSelect, cfgWriteStyle};
      pinSync <= pinMeta;
    end
  end

  // Latch the straps once, after the synchroniser has filled.
  // The arm pipe sets latchArm[1] on the same edge that pinSync fills, so the zeros that the
  // synchroniser holds out of reset are never captured.
  always_comb begin
    next_latchArm              = {latchArm[0], 1'b1};
    next_resetPinConfiguration = resetPinConfiguration;
    next_latchDone             = latchDone;
    if (latchArm[1] && !latchDone) begin
      next_resetPinConfiguration = pinSync;
      next_latchDone             = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      latchArm              <= 2'h0;
      latchDone             <= 1'b0;
      resetPinConfiguration <= 8'h00;
    end else begin
      latchArm              <= next_latchArm;
      latchDone             <= next_latchDone;
      resetPinConfiguration <= next_resetPinConfiguration;
    end
  end

  // Zero-wait APB slave
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign pslverr = 1'b0;

  function automatic logic isAddr(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  always_comb begin
    next_windowSelectReg   = windowSelectReg;
    next_windowBusModeReg  = windowBusModeReg;
    next_defaultBusModeReg = defaultBusModeReg;
    if (wrEn) begin
      if (isAddr(paddr, `EBAWS_OFF_SEL1)) begin
        next_windowSelectReg[0] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_SEL2)) begin
        next_windowSelectReg[1] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_SEL3)) begin
        next_windowSelectReg[2] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_SEL4)) begin
        next_windowSelectReg[3] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_MODE0)) begin
        next_defaultBusModeReg = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_MODE1)) begin
        next_windowBusModeReg[0] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_MODE2)) begin
        next_windowBusModeReg[1] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_MODE3)) begin
        next_windowBusModeReg[2] = pwdata[15:0];
      end else if (isAddr(paddr, `EBAWS_OFF_MODE4)) begin
        next_windowBusModeReg[3] = pwdata[15:0];
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (isAddr(paddr, `EBAWS_OFF_RSTCFG)) begin
        next_prdata = {24'h000000, resetPinConfiguration};
      end else if (isAddr(paddr, `EBAWS_OFF_SEL1)) begin
        next_prdata = {16'h0000, windowSelectReg[0]};
      end else if (isAddr(paddr, `EBAWS_OFF_SEL2)) begin
        next_prdata = {16'h0000, windowSelectReg[1]};
      end else if (isAddr(paddr, `EBAWS_OFF_SEL3)) begin
        next_prdata = {16'h0000, windowSelectReg[2]};
      end else if (isAddr(paddr, `EBAWS_OFF_SEL4)) begin
        next_prdata = {16'h0000, windowSelectReg[3]};
      end else if (isAddr(paddr, `EBAWS_OFF_MODE0)) begin
        next_prdata = {16'h0000, defaultBusModeReg};
      end else if (isAddr(paddr, `EBAWS_OFF_MODE1)) begin
        next_prdata = {16'h0000, windowBusModeReg[0]};
      end else if (isAddr(paddr, `EBAWS_OFF_MODE2)) begin
        next_prdata = {16'h0000, windowBusModeReg[1]};
      end else if (isAddr(paddr, `EBAWS_OFF_MODE3)) begin
        next_prdata = {16'h0000, windowBusModeReg[2]};
      end else if (isAddr(paddr, `EBAWS_OFF_MODE4)) begin
        next_prdata = {16'h0000, windowBusModeReg[3]};
      end else if (isAddr(paddr, `EBAWS_OFF_ROUTE)) begin
        next_prdata = {29'h00000000, routeSrc};
      end
    end else if (psel && penable) begin
      next_prdata = prdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      windowSelectReg   <= '{4{`EBAWS_SEL_RESET}};
      windowBusModeReg  <= '{4{`EBAWS_MODE_RESET}};
      defaultBusModeReg <= `EBAWS_MODE_RESET;
      prdata            <= 32'h0000_0000;
    end else begin
      windowSelectReg   <= next_windowSelectReg;
      windowBusModeReg  <= next_windowBusModeReg;
      defaultBusModeReg <= next_defaultBusModeReg;
      prdata            <= next_prdata;
    end
  end

  // Fixed peripheral mode registers are hardwired
  assign onchipPeriphBusModeReg[0] = `EBAWS_XP_MODE_RESET;
  assign onchipPeriphBusModeReg[1] = `EBAWS_XP_MODE_RESET;

  assign mIf.addr = accessAddr;
  assign mIf.sel  = windowSelectReg;

  ebaws_matcher uMatch (
    .m (mIf.match)
  );

  always_comb begin
    routeSrc      = ebaws_pkg::SRC_DEFAULT;
    routeMode     = defaultBusModeReg;
    routeExternal = 1'b1;
    if (mIf.xpHit[0]) begin
      routeSrc      = ebaws_pkg::SRC_XP0;
      routeMode     = onchipPeriphBusModeReg[0];
      routeExternal = 1'b0;
    end else if (mIf.xpHit[1]) begin
      routeSrc      = ebaws_pkg::SRC_XP1;
      routeMode     = onchipPeriphBusModeReg[1];
      routeExternal = 1'b0;
    end else if (mIf.winHit[1]) begin
      routeSrc  = ebaws_pkg::SRC_WIN2;
      routeMode = windowBusModeReg[1];
    end else if (mIf.winHit[3]) begin
      routeSrc  = ebaws_pkg::SRC_WIN4;
      routeMode = windowBusModeReg[3];
    end else if (mIf.winHit[0]) begin
      routeSrc  = ebaws_pkg::SRC_WIN1;
      routeMode = windowBusModeReg[0];
    end else if (mIf.winHit[2]) begin
      routeSrc  = ebaws_pkg::SRC_WIN3;
      routeMode = windowBusModeReg[2];
    end
  end

  assign lowByteWriteStrobeEn = !resetPinConfiguration[`EBAWS_RC_WRC];

  always_comb begin
    case (resetPinConfiguration[`EBAWS_RC_CS_LSB +: 2])
      2'h0:    chipSelectLines = 3'h3;
      2'h1:    chipSelectLines = 3'h2;
      2'h2:    chipSelectLines = 3'h0;
      default: chipSelectLines = 3'h5;
    endcase
  end

  always_comb begin
    case (resetPinConfiguration[`EBAWS_RC_SA_LSB +: 2])
      2'h0:    segmentLineCount = 4'h4;
      2'h1:    segmentLineCount = 4'h0;
      2'h2:    segmentLineCount = 4'h8;
      default: segmentLineCount = 4'h2;
    endcase
  end

  assign clockGenMode = resetPinConfiguration[`EBAWS_RC_CK_MSB:`EBAWS_RC_CK_LSB];

  xp_excl_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    !(mIf.xpHit[0] && mIf.xpHit[1])) else $error("fixed windows overlap");
  xp_first_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (|mIf.xpHit) |-> !routeExternal) else $error("fixed window not first");
  win2_prio_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (!(|mIf.xpHit) && mIf.winHit[1]) |-> routeMode == windowBusModeReg[1])
    else $error("window 2 priority lost");
  win1_sel_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (!(|mIf.xpHit) && mIf.winHit == 4'h1) |-> routeSrc == ebaws_pkg::SRC_WIN1)
    else $error("window 1 not chosen");
  default_sel_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (!(|mIf.xpHit) && mIf.winHit == 4'h0) |-> routeMode == defaultBusModeReg)
    else $error("default mode not chosen");
  cfg_ro_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    latchDone |=> $stable(resetPinConfiguration)) else $error("config changed");
  cs_none_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    resetPinConfiguration[`EBAWS_RC_CS_LSB +: 2] == 2'h2 |-> chipSelectLines == 3'h0)
    else $error("chip select decode wrong");
  seg_eight_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    resetPinConfiguration[`EBAWS_RC_SA_LSB +: 2] == 2'h2 |-> segmentLineCount == 4'h8)
    else $error("segment decode wrong");
  wr_style_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    lowByteWriteStrobeEn != resetPinConfiguration[`EBAWS_RC_WRC])
    else $error("strobe style wrong");
  win4_prio_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (!(|mIf.xpHit) && !mIf.winHit[1] && mIf.winHit[3]) |-> routeSrc == ebaws_pkg::SRC_WIN4)
    else $error("window 4 priority lost");
  win3_sel_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    (!(|mIf.xpHit) && mIf.winHit == 4'h4) |-> routeMode == windowBusModeReg[2])
    else $error("window 3 not chosen");
  ext_route_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    !(|mIf.xpHit) |-> routeExternal) else $error("external access lost");
  cs_five_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    resetPinConfiguration[`EBAWS_RC_CS_LSB +: 2] == 2'h3 |-> chipSelectLines == 3'h5)
    else $error("chip select default wrong");
endmodule

/* File: ebaws_access_model.sv */
// Access path and strap pin model facing the window selector
`timescale 1ns/10ps
module ebaws_access_model (
  input  wire logic        sys_clk,
  output logic      [23:0] accessAddr,
  output logic             cfgWriteStyle,
  output logic      [1:0]  cfgChipSelect,
  output logic      [1:0]  cfgSegment,
  output logic      [2:0]  cfgClock
);
  // Straps float high when no pulldowns are fitted
  initial begin
    accessAddr = 24'h000000;
    {cfgClock, cfgSegment, cfgChipSelect, cfgWriteStyle} = 8'hff;
  end
  // Address moves just after an edge and then holds for the whole access
  task automatic drive(input logic [23:0] a);
    @(posedge sys_clk);
    accessAddr <= a;
  endtask
  // Only called in the step that asserts reset, so the latched copy sees a stable level
  task automatic strap(input logic [7:0] s);
    {cfgClock, cfgSegment, cfgChipSelect, cfgWriteStyle} <= s;
  endtask
endmodule

/* File: tb_ebaws_top.sv */
// Self-checking bench for the address window selector
`timescale 1ns/10ps
`include "ebaws_cfg.svh"
module tb_ebaws_top;
  logic                   sys_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [15:0]            paddr = 16'h0000;
  logic [31:0]            pwdata = 32'h0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   lastErr;
  logic [23:0]            accessAddr;
  ebaws_pkg::ebaws_src_e  routeSrc;
  ebaws_pkg::ebaws_word_t routeMode;
  logic                   routeExternal;
  logic                   lowByteWriteStrobeEn;
  logic [2:0]             chipSelectLines;
  logic [3:0]             segmentLineCount;
  logic [2:0]             clockGenMode;
  logic                   cfgWriteStyle;
  logic [1:0]             cfgChipSelect;
  logic [1:0]             cfgSegment;
  logic [2:0]             cfgClock;
  int                     badCount = 0;
  int                     checkCount = 0;
  int                     selM [1:4];
  int                     modeM [0:4];
  int                     csTab [4] = '{3, 2, 0, 5};
  int                     segTab [4] = '{4, 0, 8, 2};
  logic [31:0]            lfsr = 32'd80156;
  logic [31:0]            rd;

  always #12.5 sys_clk = ~sys_clk;

  ebaws_top u_ebaws_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accessAddr(accessAddr), .routeSrc(routeSrc), .routeMode(routeMode),
    .routeExternal(routeExternal), .lowByteWriteStrobeEn(lowByteWriteStrobeEn),
    .chipSelectLines(chipSelectLines), .segmentLineCount(segmentLineCount),
    .clockGenMode(clockGenMode), .cfgWriteStyle(cfgWriteStyle),
    .cfgChipSelect(cfgChipSelect), .cfgSegment(cfgSegment), .cfgClock(cfgClock));

  ebaws_access_model u_ebaws_access_model (
    .sys_clk(sys_clk), .accessAddr(accessAddr), .cfgWriteStyle(cfgWriteStyle),
    .cfgChipSelect(cfgChipSelect), .cfgSegment(cfgSegment), .cfgClock(cfgClock));

  function automatic logic [31:0] nextRand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d}, rd);
    if (a >= `EBAWS_OFF_SEL1 && a <= `EBAWS_OFF_SEL4) selM[(a - 16'hf000) / 4 + 1] = d;
    if (a >= `EBAWS_OFF_MODE0 && a <= `EBAWS_OFF_MODE4) modeM[(a - 16'hf010) / 4] = d;
  endtask

  task automatic rdChk(input string what, input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd);
    chk(what, rd, exp);
  endtask

  function automatic bit hit(int s, logic [23:0] a);
    int sz = s & 15;
    return sz <= 11 && ((a[23:12] >> sz) == (s[15:4] >> sz));
  endfunction

  function automatic int expSrc(logic [23:0] a);
    if (a[23:12] == `EBAWS_XP0_START) return 5;
    if (a[23:12] == `EBAWS_XP1_START) return 6;
    if (hit(selM[2], a)) return 2;
    if (hit(selM[4], a)) return 4;
    if (hit(selM[1], a)) return 1;
    if (hit(selM[3], a)) return 3;
    return 0;
  endfunction

  task automatic route(input logic [23:0] a);
    int e;
    u_ebaws_access_model.drive(a);
    @(negedge sys_clk);
    e = expSrc(a);
    chk("routeSrc", 32'(routeSrc), e);
    chk("routeMode", 32'(routeMode), e < 5 ? modeM[e] : 0);
    chk("routeExternal", 32'(routeExternal), e < 5);
  endtask

  task automatic doReset(input logic [7:0] s);
    u_ebaws_access_model.strap(s);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    foreach (selM[i]) selM[i] = 0;
    foreach (modeM[i]) modeM[i] = 0;
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Generous bound: the whole run needs a few hundred cycles
  initial begin
    #(25 * 20000);
    badCount++;
    stopTest();
  end

  initial begin
    logic [7:0]  s;
    logic [31:0] r;
    logic [15:0] w;
    int          b;
    int          lo;
    int          sz;
    int          addrs [18] = '{'h0ffff, 'h100000, 'h104fff, 'h105000, 'h105fff, 'h106000,
                                'h11ffff, 'h120000, 'h00e123, 'h00f000, 'h010000, 'h7fffff,
                                'h800000, 'h900000, 'h903fff, 'h904000, 'hffffff, 'h00dfff};
    for (int k = 0; k < 4; k++) begin
      s = {3'(k * 2 + 1), 2'(3 - k), 2'(k), 1'(k)};
      doReset(s);
      chk("writeStyle", 32'(lowByteWriteStrobeEn), !s[0]);
      chk("csLines", 32'(chipSelectLines), csTab[k]);
      chk("segLines", 32'(segmentLineCount), segTab[3 - k]);
      chk("clkMode", 32'(clockGenMode), s[7:5]);
      rdChk("rstCfg", `EBAWS_OFF_RSTCFG, 32'(s));
      wr(`EBAWS_OFF_RSTCFG, 16'(nextRand()));
      chk("pslverr", 32'(lastErr), 0);
      rdChk("rstCfgWritten", `EBAWS_OFF_RSTCFG, 32'(s));
      $display("strap test %0d done", k);
    end
    for (int i = 0; i < 9; i++) rdChk("regReset", 16'hf000 + 16'(4 * i), 0);
    rdChk("routeReset", `EBAWS_OFF_ROUTE, expSrc(accessAddr));
    rdChk("unmapped", 16'hf0fc, 0);
    for (int i = 0; i < 5; i++) wr(`EBAWS_OFF_MODE0 + 16'(4 * i), 16'(nextRand()));
    for (int i = 0; i < 5; i++) rdChk("modeReg", `EBAWS_OFF_MODE0 + 16'(4 * i), modeM[i]);
    $display("register test done");
    // Only nested overlaps are programmed: window 2 in 1, window 4 in 3
    wr(`EBAWS_OFF_SEL1, {12'h11f, 4'h5});
    wr(`EBAWS_OFF_SEL2, {12'h105, 4'h0});
    wr(`EBAWS_OFF_SEL3, {12'h8ab, 4'hb});
    wr(`EBAWS_OFF_SEL4, {12'h900, 4'h2});
    foreach (addrs[i]) route(24'(addrs[i]));
    for (int i = 0; i < 20; i++) route(24'(nextRand()));
    route(24'h105010);
    rdChk("routeStatus", `EBAWS_OFF_ROUTE, expSrc(24'h105010));
    $display("priority test done");
    // Reserved codes keep the other windows out of the way
    wr(`EBAWS_OFF_SEL2, 16'h000f);
    wr(`EBAWS_OFF_SEL3, 16'h000c);
    wr(`EBAWS_OFF_SEL4, 16'h000e);
    for (int z = 0; z < 16; z++) begin
      r = nextRand();
      w = {r[15:4], 4'(z)};
      wr(`EBAWS_OFF_SEL1, w);
      b = (w[15:4] >> (z % 12)) << (z % 12);
      lo = b << 12;
      sz = 4096 << (z % 12);
      route(24'(lo));
      route(24'(lo + sz - 1));
      route(24'(lo + sz));
      route(24'(lo - 1));
    end
    $display("size test done");
    stopTest();
  end
endmodule
